/* File: inc/scsg_pkg.sv */
// Constants, types and strap table for the switching clock and sync generator.
// Assumes a single 200 MHz system clock.
package scsg_pkg;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int REF_KHZ = 16000;
    localparam int DIV_W = 7;
    localparam int CNT_W = 11;
    localparam int FREQ_W = 11;
    localparam int STRAP_W = 5;

    // 16 MHz reference from 200 MHz: 2 pulses per 25 cycles
    localparam logic [4:0] ACC_STEP = 5'h02;
    localparam logic [4:0] ACC_MOD = 5'h19;

    localparam logic [14:0] REF_KHZ_V = 15'h3E80;
    localparam logic [DIV_W-1:0] DIV_MIN = 7'h0B;
    localparam logic [DIV_W-1:0] DIV_MAX = 7'h50;
    localparam logic [DIV_W-1:0] DIV_N_RST = 7'h28;
    localparam logic [FREQ_W-1:0] FREQ_MIN_KHZ = 11'h0C8;
    localparam logic [FREQ_W-1:0] FREQ_MAX_KHZ = 11'h535;

    // Loss timeout must exceed the 5 us period of the slowest external clock
    localparam int TIMEOUT_NS = 6000;
    localparam int TIMEOUT_CYC = (TIMEOUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MIN_PER_NS = 750;
    localparam int MIN_PER_CYC = (MIN_PER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [CNT_W-1:0] TIMEOUT_CNT = CNT_W'(TIMEOUT_CYC);
    localparam logic [CNT_W-1:0] MIN_PER_CNT = CNT_W'(MIN_PER_CYC);

    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam logic [STRAP_W-1:0] STRAP_LOW = 5'h00;
    localparam logic [STRAP_W-1:0] STRAP_OPEN = 5'h01;
    localparam logic [STRAP_W-1:0] STRAP_HIGH = 5'h02;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DETECT = 4'b0010,
        ST_EXT = 4'b0100,
        ST_INT = 4'b1000
    } scsg_state_t;

    typedef struct packed {
        logic wr;
        logic [FREQ_W-1:0] khz;
    } scsg_freq_cmd_t;

    // Strap code to divider: LOW, OPEN, HIGH, then resistors in ascending order
    function automatic logic [DIV_W-1:0] scsg_strap_div(input logic [STRAP_W-1:0] code);
        case (code)
            5'h00: scsg_strap_div = 7'h35;
            5'h01: scsg_strap_div = 7'h28;
            5'h02: scsg_strap_div = 7'h21;
            5'h03: scsg_strap_div = 7'h50;
            5'h04: scsg_strap_div = 7'h48;
            5'h05: scsg_strap_div = 7'h42;
            5'h06: scsg_strap_div = 7'h3C;
            5'h07: scsg_strap_div = 7'h38;
            5'h08: scsg_strap_div = 7'h32;
            5'h09: scsg_strap_div = 7'h2C;
            5'h0A: scsg_strap_div = 7'h2A;
            5'h0B: scsg_strap_div = 7'h25;
            5'h0C: scsg_strap_div = 7'h23;
            5'h0D: scsg_strap_div = 7'h1E;
            5'h0E: scsg_strap_div = 7'h1C;
            5'h0F: scsg_strap_div = 7'h1A;
            5'h10: scsg_strap_div = 7'h16;
            5'h11: scsg_strap_div = 7'h14;
            5'h12: scsg_strap_div = 7'h13;
            5'h13: scsg_strap_div = 7'h12;
            5'h14: scsg_strap_div = 7'h0F;
            5'h15: scsg_strap_div = 7'h0E;
            5'h16: scsg_strap_div = 7'h0D;
            5'h17: scsg_strap_div = 7'h0C;
            default: scsg_strap_div = DIV_N_RST;
        endcase
    endfunction

    function automatic logic [DIV_W-1:0] scsg_div_clamp(input logic [DIV_W-1:0] n);
        if (n < DIV_MIN) begin
            scsg_div_clamp = DIV_MIN;
        end else if (n > DIV_MAX) begin
            scsg_div_clamp = DIV_MAX;
        end else begin
            scsg_div_clamp = n;
        end
    endfunction
endpackage

/* File: hw/scsg_divider.sv */
// Integer divider of the 16 MHz reference enable into the switching clock.
// Assumes ref_en_i is a one-cycle pulse at the reference rate.
`timescale 1ns/1ps
module scsg_divider
    import scsg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ref_en_i,
    input wire logic restart_i,
    input wire logic [DIV_W-1:0] div_n_i,
    output logic clk_o,
    output logic start_o
);
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] n_reg;
    wire [DIV_W-1:0] n_load = scsg_div_clamp(div_n_i);
    wire wrap = ref_en_i && (cnt_reg >= n_reg - 7'h01);

    // R1: divide reference by bounded integer
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
            n_reg <= DIV_N_RST;
        end else if (restart_i) begin
            // Resume in the low half so the handover never makes a runt pulse
            cnt_reg <= n_load >> 1;
            n_reg <= n_load;
        end else if (wrap) begin
            cnt_reg <= '0;
            n_reg <= n_load;
        end else if (ref_en_i) begin
            cnt_reg <= cnt_reg + 7'h01;
        end
    end

    assign clk_o = cnt_reg < (n_reg >> 1);
    assign start_o = wrap;

    // R1: divider stays in range
    div_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R1
        (n_reg >= DIV_MIN) && (n_reg <= DIV_MAX) && (cnt_reg < n_reg))
        else $error("divider count or ratio out of range");
endmodule

/* File: hw/scsg_sync_mon.sv */
// Edge tracker and loss timer for the synchronised sync input.
// Assumes lvl_i has already passed a two-stage synchroniser.
`timescale 1ns/1ps
module scsg_sync_mon
    import scsg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic restart_i,
    input wire logic lvl_i,
    output logic edge_o,
    output logic good_o,
    output logic stale_o
);
    logic prev_reg;
    logic seen_reg;
    logic [CNT_W-1:0] cnt_reg;

    assign edge_o = lvl_i && !prev_reg;
    // R15: no edge within the timeout
    assign stale_o = cnt_reg >= TIMEOUT_CNT;
    // R8: a period shorter than the fastest legal clock is not trusted
    assign good_o = edge_o && seen_reg && (cnt_reg >= MIN_PER_CNT);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prev_reg <= 1'b0;
            seen_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            prev_reg <= lvl_i;
            if (restart_i) begin
                seen_reg <= 1'b0;
                cnt_reg <= '0;
            end else if (edge_o) begin
                seen_reg <= 1'b1;
                cnt_reg <= '0;
            end else if (!stale_o) begin
                cnt_reg <= cnt_reg + 11'h001;
            end
        end
    end

    stale_time_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R15
        (cnt_reg == TIMEOUT_CNT - 11'h001) && !edge_o && !restart_i |=> stale_o)
        else $error("loss not declared at timeout");

    fast_reject_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R8
        edge_o && (cnt_reg < MIN_PER_CNT) |-> !good_o)
        else $error("too short period accepted");
endmodule

/* File: hw/scsg_top.sv */
// Switching clock generator with strap or command divider and sync pin handling.
// Assumes straps are static after power-up and the mode input comes from local logic.
`timescale 1ns/1ps
// Function
// R1: Switching clock is the 16 MHz reference divided by an integer up to 80.
// R2: Frequency settable by strap or command from 200 kHz to 1333 kHz.
// R3: At power-up the sync strap code selects a fixed frequency from the table.
// R4: Users should avoid 500 and 1000 kHz, preferring 533 and 1067 kHz.
// R5: Internal clocking follows a loop whose reference may be the sync pin clock.
// R6: Sync pin is an input after reset; checked at every channel enable assertion.
// R7: A detected external clock is followed on its rising edges.
// R8: External clock lies within 200 kHz to 1.33 MHz and is stable at enable.
// R9: External clock stays within 10 percent of its starting frequency.
// R10: Any external frequency in range is tracked, not only divider values.
// R11: On loss of external clock, fall back to internal programmed frequency.
// R12: One group member drives its sync pin as output from its internal clock.
// R13: With the sync pin as output, no incoming clock check at enable.
// R14: A command frequency picks the whole divider giving the closest frequency.
// R15: No edge within a timeout means loss; switch to internal without glitches.
module scsg_top
    import scsg_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CHANNEL0_ENABLE_I,
    input wire logic CHANNEL1_ENABLE_I,
    input wire logic [STRAP_W-1:0] SYNC_STRAP_RESISTOR_I,
    input wire logic SYNC_OUT_MODE_I,
    input wire scsg_freq_cmd_t FREQ_CMD_I,
    input wire logic SYNC_I,
    output logic SYNC_O,
    output logic SYNC_OE_O,
    output logic SW_CLK_O,
    output logic SW_START_O,
    output logic PLL_REF_EXT_O,
    output logic [DIV_W-1:0] DIV_N_O
);
    // Pin synchronisers: bit 0 and 1 channel enables, bit 2 sync pin
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic [STRAP_W-1:0] strap_meta_reg;
    logic [STRAP_W-1:0] strap_sync_reg;
    logic [1:0] en_prev_reg;
    logic [1:0] strap_wait_reg;
    logic strap_done_reg;
    logic [4:0] acc_reg;
    logic [4:0] acc_next;
    logic ref_en_reg;
    scsg_freq_cmd_t cmd_reg;
    logic [DIV_W-1:0] div_n_reg;
    logic [DIV_W-1:0] div_n_next;
    scsg_state_t state_reg;
    scsg_state_t state_next;
    logic sw_clk_reg;
    logic sw_start_reg;
    logic ref_ext_reg;
    logic sync_o_reg;
    logic sync_oe_reg;
    logic int_clk;
    logic int_start;
    logic mon_edge;
    logic mon_good;
    logic mon_stale;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
            strap_meta_reg <= '0;
            strap_sync_reg <= '0;
        end else begin
            pin_meta_reg <= {SYNC_I, CHANNEL1_ENABLE_I, CHANNEL0_ENABLE_I};
            pin_sync_reg <= pin_meta_reg;
            strap_meta_reg <= SYNC_STRAP_RESISTOR_I;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    wire [1:0] en_lvl = pin_sync_reg[1:0];
    wire sync_lvl = pin_sync_reg[2];
    // R6: either channel enable rising starts a check
    wire en_rise = |(en_lvl & ~en_prev_reg);
    wire out_mode = SYNC_OUT_MODE_I;
    wire strap_take = !strap_done_reg && (strap_wait_reg == STRAP_SETTLE);

    // R3: strap is caught once, after its synchroniser has filled
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            en_prev_reg <= '0;
            strap_wait_reg <= '0;
            strap_done_reg <= 1'b0;
        end else begin
            en_prev_reg <= en_lvl;
            if (!strap_done_reg && !strap_take) begin
                strap_wait_reg <= strap_wait_reg + 2'h1;
            end
            if (strap_take) begin
                strap_done_reg <= 1'b1;
            end
        end
    end

    // Fractional accumulator gives an average 16 MHz rate; jitter is one system cycle
    wire [5:0] acc_sum = {1'b0, acc_reg} + {1'b0, ACC_STEP};
    wire acc_wrap = acc_sum >= {1'b0, ACC_MOD};
    assign acc_next = acc_wrap ? 5'(acc_sum - {1'b0, ACC_MOD}) : acc_sum[4:0];

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            acc_reg <= '0;
            ref_en_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            ref_en_reg <= acc_wrap;
        end
    end

    // R2: command frequency is held inside the supported span
    wire [FREQ_W-1:0] f_c = (cmd_reg.khz < FREQ_MIN_KHZ) ? FREQ_MIN_KHZ :
                            (cmd_reg.khz > FREQ_MAX_KHZ) ? FREQ_MAX_KHZ : cmd_reg.khz;
    wire [14:0] n_quot = REF_KHZ_V / {4'h0, f_c};
    wire [DIV_W-1:0] n_lo = n_quot[DIV_W-1:0];
    wire [DIV_W-1:0] n_hi = n_lo + 7'h01;
    // R14: compare distances to both neighbouring quotients without dividing again
    wire [25:0] dist_lo = 26'(REF_KHZ_V) * 26'({n_lo, 1'b1});
    wire [25:0] dist_hi = 26'(f_c) * 26'({n_lo, 1'b0}) * 26'(n_hi);
    wire [DIV_W-1:0] n_near = (dist_lo <= dist_hi) ? n_lo : n_hi;

    always_comb begin
        div_n_next = div_n_reg;
        if (strap_take) begin
            div_n_next = scsg_strap_div(strap_sync_reg);
        end else if (cmd_reg.wr) begin
            div_n_next = scsg_div_clamp(n_near);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            cmd_reg <= '0;
            div_n_reg <= DIV_N_RST;
        end else begin
            cmd_reg <= FREQ_CMD_I;
            div_n_reg <= div_n_next;
        end
    end

    // R15: any exit from the external clock resumes in the low half, so no runt pulse
    wire div_restart = (state_reg == ST_EXT) && (state_next != ST_EXT);

    scsg_divider u_div (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .ref_en_i(ref_en_reg),
        .restart_i(div_restart),
        .div_n_i(div_n_reg),
        .clk_o(int_clk),
        .start_o(int_start)
    );

    scsg_sync_mon u_mon (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .restart_i(en_rise),
        .lvl_i(sync_lvl),
        .edge_o(mon_edge),
        .good_o(mon_good),
        .stale_o(mon_stale)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                // R6: check at enable; R13: never in output mode
                if (en_rise && !out_mode) begin
                    state_next = ST_DETECT;
                end
            end
            ST_DETECT: begin
                if (out_mode) begin
                    state_next = ST_IDLE;
                end else if (en_rise) begin
                    state_next = ST_DETECT;
                end else if (mon_good) begin
                    state_next = ST_EXT;
                end else if (mon_stale) begin
                    state_next = ST_INT;
                end
            end
            ST_EXT: begin
                // R11: loss returns to internal oscillator; R6: a new enable checks again first
                if (out_mode) begin
                    state_next = ST_INT;
                end else if (en_rise) begin
                    state_next = ST_DETECT;
                end else if (mon_stale) begin
                    state_next = ST_INT;
                end
            end
            ST_INT: begin
                if (en_rise && !out_mode) begin
                    state_next = ST_DETECT;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    wire on_ext = state_reg == ST_EXT;
    // R7: follow the external rising edge; R10: any period in range
    wire sw_clk_next = on_ext ? sync_lvl : int_clk;
    wire sw_start_next = on_ext ? mon_edge : int_start;
    // R12: lead device drives its internal clock out
    wire sync_o_next = out_mode && int_clk;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            state_reg <= ST_IDLE;
            sw_clk_reg <= 1'b0;
            sw_start_reg <= 1'b0;
            ref_ext_reg <= 1'b0;
            sync_o_reg <= 1'b0;
            sync_oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sw_clk_reg <= sw_clk_next;
            sw_start_reg <= sw_start_next;
            // R5: loop reference taken from the sync pin while locked
            ref_ext_reg <= state_next == ST_EXT;
            sync_o_reg <= sync_o_next;
            // R6: pin stays an input unless output mode is chosen
            sync_oe_reg <= out_mode;
        end
    end

    assign SW_CLK_O = sw_clk_reg;
    assign SW_START_O = sw_start_reg;
    assign PLL_REF_EXT_O = ref_ext_reg;
    assign SYNC_O = sync_o_reg;
    assign SYNC_OE_O = sync_oe_reg;
    assign DIV_N_O = div_n_reg;

    sequence enable_check_s;
        en_rise && !out_mode;
    endsequence

    sequence enter_detect_s;
        state_reg == ST_DETECT;
    endsequence

    detect_on_en_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R6
        enable_check_s |=> enter_detect_s)
        else $error("enable did not start a sync check");

    pin_input_rst_a: assert property (@(posedge CLK_I) // R6
        !RST_N_I |=> !SYNC_OE_O)
        else $error("sync pin driven during reset");

    out_no_check_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R13
        out_mode && $past(out_mode) |-> state_reg != ST_DETECT)
        else $error("sync checked while pin is an output");

    lead_drive_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R12
        out_mode |=> SYNC_OE_O && (SYNC_O == $past(int_clk)) && !PLL_REF_EXT_O)
        else $error("lead device not driving its own clock");

    ext_follow_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R7
        on_ext && mon_edge |=> SW_START_O && SW_CLK_O)
        else $error("external rising edge not followed");

    loss_fallback_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R11
        on_ext && mon_stale && !en_rise |=> (state_reg == ST_INT) && !PLL_REF_EXT_O ##1 !SW_CLK_O)
        else $error("no fallback to internal clock after loss");

    strap_low_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R3
        strap_take && (strap_sync_reg == STRAP_LOW) |=> DIV_N_O == 7'h35)
        else $error("low strap did not select its divider");

    strap_high_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R3
        strap_take && (strap_sync_reg == STRAP_HIGH) |=> DIV_N_O == 7'h21)
        else $error("high strap did not select its divider");

    cmd_nearest_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R14
        FREQ_CMD_I.wr && (FREQ_CMD_I.khz == 11'h32A) && !strap_take ##1 !strap_take |=> DIV_N_O == 7'h14)
        else $error("command frequency not rounded to nearest divider");

    cmd_span_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // R2
        FREQ_CMD_I.wr && (FREQ_CMD_I.khz > FREQ_MAX_KHZ) && !strap_take ##1 !strap_take |=> DIV_N_O == 7'h0C)
        else $error("command above span not held at top rate");
endmodule

/* File: verification/scsg_ext_clk.sv */
// Behavioural external clock source for the shared sync wire.
// Assumes a pull-down on the wire, so a released source reads low.
`timescale 1ns/1ps
module scsg_ext_clk (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic [9:0] half_i,
    output logic drv_o,
    output logic oe_o
);
    logic drv_reg = 1'b0;
    logic oe_reg = 1'b0;
    logic [9:0] cnt_reg = 10'h000;

    assign drv_o = drv_reg;
    assign oe_o = oe_reg;

    // steady period
    // Stops only in the low phase so the release adds no stray rising edge
    always @(posedge clk_i) begin
        if (!run_i && !drv_reg) begin
            oe_reg <= 1'b0;
            cnt_reg <= 10'h000;
        end else if (cnt_reg + 10'h001 >= half_i) begin
            oe_reg <= 1'b1;
            drv_reg <= ~drv_reg;
            cnt_reg <= 10'h000;
        end else begin
            oe_reg <= 1'b1;
            cnt_reg <= cnt_reg + 10'h001;
        end
    end
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the switching clock and sync generator.
// Assumes the external clock model and a pull-down on the shared sync wire.
`timescale 1ns/1ps
module testbench
    import scsg_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en0 = 1'b0;
    logic en1 = 1'b0;
    logic out_mode = 1'b0;
    logic [STRAP_W-1:0] strap = 5'h0D;
    scsg_freq_cmd_t cmd = '0;
    logic sync_wire, sync_o, sync_oe, sw_clk, sw_start, pll_ext;
    logic [DIV_W-1:0] div_n;
    logic src_run = 1'b0;
    logic [9:0] src_half = 10'h0A7;
    logic src_drv, src_oe;
    int fail_count = 0;
    int checks = 0;

    always #2.5 clk = ~clk;

    // Pull-down holds the wire low when nobody drives it
    assign sync_wire = sync_oe ? sync_o : (src_oe ? src_drv : 1'b0);

    scsg_top scsg_top_inst (
        .CLK_I(clk),
        .RST_N_I(rst_n),
        .CHANNEL0_ENABLE_I(en0),
        .CHANNEL1_ENABLE_I(en1),
        .SYNC_STRAP_RESISTOR_I(strap),
        .SYNC_OUT_MODE_I(out_mode),
        .FREQ_CMD_I(cmd),
        .SYNC_I(sync_wire),
        .SYNC_O(sync_o),
        .SYNC_OE_O(sync_oe),
        .SW_CLK_O(sw_clk),
        .SW_START_O(sw_start),
        .PLL_REF_EXT_O(pll_ext),
        .DIV_N_O(div_n)
    );

    scsg_ext_clk scsg_ext_clk_inst (
        .clk_i(clk),
        .run_i(src_run),
        .half_i(src_half),
        .drv_o(src_drv),
        .oe_o(src_oe)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("Counts: checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic timeout();
        fail_count++;
        $display("ERROR t=%0t seen=%h exp=%h", $time, 0, 1);
        stop_test();
    endtask

    // nearest whole divider, ties to the higher frequency
    function automatic logic [DIV_W-1:0] near_div(input int khz);
        int f;
        int n;
        f = (khz < int'(FREQ_MIN_KHZ)) ? int'(FREQ_MIN_KHZ) : khz;
        f = (f > int'(FREQ_MAX_KHZ)) ? int'(FREQ_MAX_KHZ) : f;
        n = REF_KHZ / f;
        if (2 * f * n * (n + 1) < REF_KHZ * (2 * n + 1)) begin
            n++;
        end
        near_div = DIV_W'(n);
    endfunction

    // Sel 0 watches the lock flag, 1 the period pulse, 2 the source drive enable
    task automatic wait_for(input int sel, input logic val, output int n);
        logic s;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            s = (sel == 0) ? pll_ext : ((sel == 1) ? sw_start : src_oe);
        end while (s !== val && n < 3000);
        if (n >= 3000) begin
            timeout();
        end
    endtask

    task automatic period(output int p);
        int n;
        wait_for(1, 1'b1, n);
        wait_for(1, 1'b1, p);
    endtask

    task automatic send_cmd(input int khz);
        @(posedge clk);
        cmd <= '{wr: 1'b1, khz: FREQ_W'(khz)};
        @(posedge clk);
        cmd.wr <= 1'b0;
    endtask

    task automatic t_reset_strap();
        @(negedge clk);
        check(16'({sw_clk, sw_start, pll_ext, sync_oe, sync_o}), 16'h0000);
        check(16'(div_n), 16'h0028);
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        check(16'(div_n), 16'h0028);
        repeat (3) @(posedge clk);
        @(negedge clk);
        check(16'(div_n), 16'(near_div(533)));
    endtask

    task automatic t_cmd_table();
        // stimulus stays off the 500 and 1000 kHz points
        int khz [9] = '{810, 200, 1333, 100, 2000, 533, 1067, 302, 400};
        int p;
        foreach (khz[i]) begin
            send_cmd(khz[i]);
            repeat (2) @(posedge clk);
            @(negedge clk);
            check(16'(div_n), 16'(near_div(khz[i])));
        end
        @(posedge clk);
        cmd <= '{wr: 1'b1, khz: 11'h42B};
        @(posedge clk);
        cmd <= '{wr: 1'b1, khz: 11'h32A};
        @(posedge clk);
        cmd.wr <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(16'(div_n), 16'h0014);
        // Twenty reference pulses at 12.5 cycles each
        period(p);
        check(16'(p), 16'h00FA);
    endtask

    task automatic t_ext_lock();
        int n;
        int p;
        @(posedge clk);
        src_run <= 1'b1;
        repeat (700) @(posedge clk);
        en0 <= 1'b1;
        wait_for(0, 1'b1, n);
        check(16'(n < 1100), 16'h0001);
        check(16'(sync_oe), 16'h0000);
        // Period off the divider grid must still be followed
        period(p);
        check(16'(p), 16'h014E);
    endtask

    task automatic t_loss();
        int n;
        wait_for(1, 1'b1, n);
        @(posedge clk);
        src_run <= 1'b0;
        wait_for(2, 1'b0, n);
        wait_for(0, 1'b0, n);
        // Last rise came one high phase before the release
        check(16'(n > 1000 && n < 1100), 16'h0001);
        // First pulse closes the shortened restart period
        period(n);
        check(16'(n), 16'h00FA);
    endtask

    task automatic t_fallback();
        int p;
        int h;
        period(p);
        check(16'(p), 16'h00FA);
        h = 0;
        repeat (250) begin
            @(negedge clk);
            h += (sw_clk === 1'b1) ? 1 : 0;
        end
        // Ten of twenty reference counts high
        check(16'(h), 16'h007D);
    endtask

    task automatic t_strap_again(input logic [STRAP_W-1:0] code, input logic [15:0] exp);
        @(posedge clk);
        rst_n <= 1'b0;
        out_mode <= 1'b0;
        strap <= code;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check(16'({pll_ext, sync_oe}), 16'h0000);
        check(16'(div_n), exp);
    endtask

    task automatic t_relock();
        int n;
        int p;
        @(posedge clk);
        en0 <= 1'b0;
        src_half <= 10'h12C;
        src_run <= 1'b1;
        repeat (1500) @(posedge clk);
        en1 <= 1'b1;
        wait_for(0, 1'b1, n);
        period(p);
        check(16'(p), 16'h0258);
    endtask

    task automatic t_out_mode();
        int n;
        int r;
        logic last;
        @(posedge clk);
        src_run <= 1'b0;
        en1 <= 1'b0;
        wait_for(2, 1'b0, n);
        // source kept off the wire while the device leads
        @(posedge clk);
        out_mode <= 1'b1;
        repeat (3) @(posedge clk);
        en0 <= 1'b1;
        @(negedge clk);
        check(16'(sync_oe), 16'h0001);
        r = 0;
        n = 0;
        last = sync_o;
        repeat (2000) begin
            @(negedge clk);
            if (pll_ext !== 1'b0) begin
                n++;
            end
            if (sync_o === 1'b1 && last === 1'b0) begin
                r++;
            end
            last = sync_o;
        end
        check(16'(n), 16'h0000);
        check(16'(r >= 7 && r <= 9), 16'h0001);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        t_reset_strap();
        t_cmd_table();
        t_ext_lock();
        t_loss();
        t_fallback();
        t_relock();
        t_out_mode();
        t_strap_again(STRAP_LOW, 16'h0035);
        t_strap_again(STRAP_HIGH, 16'h0021);
        stop_test();
    end
endmodule
